// file: flk_cmd.sv
// Serial flash command block: lock bits, software reset, unique ID and
// parameter table reads, behind the chip select, serial clock and I/O pins.
// Assumes the host holds quad_command_mode stable while chip select is low,
// and keeps chip select high for at least two serial clock periods.
// Overview of operation
// RULE1 - no-action command only cancels reset arm
// RULE2 - lock bits protect only when scheme is 1
// RULE3 - lock bits are one after any reset
// RULE4 - 36h plus address locks block or sector
// RULE5 - 39h plus address unlocks block or sector
// RULE6 - host sets write latch before lock commands
// RULE7 - partial last byte rejects lock commands
// RULE8 - 3Dh plus address returns lock bit
// RULE9 - status one is read-only, zero writable
// RULE10 - 7Eh alone locks the whole chip
// RULE11 - 98h alone unlocks the whole chip
// RULE12 - opcode in 8 SPI or 2 quad clocks
// RULE13 - arm then execute restores power-on defaults
// RULE14 - execute only directly after arm command
// RULE15 - software reset aborts program or erase
// RULE16 - 4Bh, four dummies, then 128-bit ID
// RULE17 - 5Ah, address, dummy, table until deselect
// RULE18 - locked block program and erase are ignored
`timescale 1ns/10ps
module flk_cmd #(
  // Arbitrary default value, to be set per part.
  parameter logic [127:0] UNIQUE_ID = 128'h0123456789ABCDEF0F1E2D3C4B5A6978
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [3:0] io_in,
  output logic [3:0] io_out,
  output logic [3:0] io_oe,
  input wire logic quad_command_mode,
  input wire logic lock_scheme_select,
  input wire logic range_protect,
  input wire logic write_latch,
  input wire logic pe_req,
  input wire logic [23:0] pe_addr,
  input wire logic pe_busy,
  output logic pe_grant,
  output logic pe_deny,
  output logic pe_abort,
  output logic soft_reset
);
  import flk_pkg::*;

  // ****************************************
  // Link side, on the serial clock
  // ****************************************
  logic [7:0] shift_ff;
  logic [7:0] link_byte_ff;
  logic edge_tgl_ff;
  logic [3:0] wrap_ff;
  logic [6:0] edges_ff;
  logic arm_s1_ff;
  logic arm_s2_ff;
  logic long_s1_ff;
  logic long_s2_ff;
  logic [3:0] io_out_ff;
  logic [3:0] io_oe_ff;
  logic mode_ff;
  logic out_arm_ff;
  logic out_long_ff;
  logic [7:0] buf0_ff;
  logic [7:0] buf1_ff;
  logic [7:0] nxt_shift;
  logic byte_end;
  logic [7:0] cur_buf;
  logic [6:0] out_edge;

  always_comb begin
    if (mode_ff) begin
      nxt_shift = {shift_ff[3:0], io_in}; // RULE12
    end else begin
      nxt_shift = {shift_ff[6:0], io_in[0]}; // RULE12
    end
  end

  assign byte_end = mode_ff ? wrap_ff[0] : (wrap_ff[2:0] == SPI_LAST_EDGE);

  // Data registers keep their value across frames so the last byte survives deselect.
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      shift_ff <= 8'h00;
      link_byte_ff <= 8'h00;
      edge_tgl_ff <= 1'b0;
    end else begin
      shift_ff <= nxt_shift;
      edge_tgl_ff <= ~edge_tgl_ff;
      if (byte_end) begin
        link_byte_ff <= nxt_shift;
      end
    end
  end

  // Frame counters and the output request synchroniser restart with every frame.
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      wrap_ff <= 4'h0;
      edges_ff <= 7'h00;
      arm_s1_ff <= 1'b0;
      arm_s2_ff <= 1'b0;
      long_s1_ff <= 1'b0;
      long_s2_ff <= 1'b0;
    end else begin
      wrap_ff <= wrap_ff + 4'h1;
      if (edges_ff != EDGE_SAT) begin
        edges_ff <= edges_ff + 7'h01;
      end
      arm_s1_ff <= out_arm_ff;
      arm_s2_ff <= arm_s1_ff;
      long_s1_ff <= out_long_ff;
      long_s2_ff <= long_s1_ff;
    end
  end

  always_comb begin
    if (mode_ff) begin
      cur_buf = wrap_ff[1] ? buf1_ff : buf0_ff;
      out_edge = long_s2_ff ? QUAD_OUT_EDGE_LONG : QUAD_OUT_EDGE;
    end else begin
      cur_buf = wrap_ff[3] ? buf1_ff : buf0_ff;
      out_edge = long_s2_ff ? SPI_OUT_EDGE_LONG : SPI_OUT_EDGE;
    end
  end

  // Output lanes change on the falling edge so the host samples them on the rising one.
  always_ff @(negedge sclk or posedge cs_n or posedge rst) begin
    if (cs_n || rst) begin
      io_out_ff <= 4'h0;
      io_oe_ff <= 4'h0;
    end else if (arm_s2_ff && (edges_ff >= out_edge)) begin
      if (mode_ff) begin
        io_oe_ff <= 4'hF;
        io_out_ff <= wrap_ff[0] ? cur_buf[3:0] : cur_buf[7:4];
      end else begin
        io_oe_ff <= 4'h2;
        io_out_ff <= {2'h0, cur_buf[3'h7 - wrap_ff[2:0]], 1'b0};
      end
    end else begin
      io_out_ff <= 4'h0;
      io_oe_ff <= 4'h0;
    end
  end

  assign io_out = io_out_ff;
  assign io_oe = io_oe_ff;

  // ****************************************
  // Pin synchronisers, on the system clock
  // ****************************************
  logic [1:0] raw_in;
  logic [1:0] s1_ff;
  logic [1:0] s2_ff;
  logic [1:0] s3_ff;
  logic [1:0] acc_ff;
  logic [1:0] chg;

  assign raw_in = {edge_tgl_ff, cs_n};

  for (genvar g = 0; g < 2; g++) begin : g_sync
    always_ff @(posedge clock) begin
      if (rst) begin
        s1_ff[g] <= SYNC_RESET[g];
        s2_ff[g] <= SYNC_RESET[g];
        s3_ff[g] <= SYNC_RESET[g];
        acc_ff[g] <= SYNC_RESET[g];
      end else begin
        s1_ff[g] <= raw_in[g];
        s2_ff[g] <= s1_ff[g];
        s3_ff[g] <= s2_ff[g];
        if (chg[g]) begin
          acc_ff[g] <= s3_ff[g];
        end
      end
    end
    assign chg[g] = (s2_ff[g] == s3_ff[g]) && (s3_ff[g] != acc_ff[g]);
  end

  // ****************************************
  // Command decode, on the system clock
  // ****************************************
  logic frame_start;
  logic frame_end;
  logic byte_done;
  logic [2:0] ecnt_ff;
  logic [4:0] bidx_ff;
  logic [7:0] op_ff;
  logic [23:0] addr_ff;
  logic arm_ff;
  logic [N_SECTORS-1:0] lock_ff;
  logic soft_reset_ff;
  logic pe_abort_ff;
  logic pe_grant_ff;
  logic pe_deny_ff;
  logic [23:0] nxt_addr;
  logic [7:0] lock_byte;
  logic [7:0] pre_byte;
  logic [5:0] pre_idx;
  logic whole;
  logic do_single_lock;
  logic do_single_unlock;
  logic do_all_lock;
  logic do_all_unlock;
  logic do_arm;
  logic do_reset;
  logic prot;

  assign frame_start = chg[0] && !s3_ff[0];
  assign frame_end = chg[0] && s3_ff[0];
  assign byte_done = chg[1] && (ecnt_ff == (mode_ff ? QUAD_LAST_EDGE : SPI_LAST_EDGE)); // RULE12
  assign whole = (ecnt_ff == 3'h0); // RULE7
  assign do_single_lock = frame_end && whole && write_latch && (op_ff == OP_SINGLE_LOCK)
                          && (bidx_ff == LEN_WITH_ADDRESS); // RULE4
  assign do_single_unlock = frame_end && whole && write_latch && (op_ff == OP_SINGLE_UNLOCK)
                            && (bidx_ff == LEN_WITH_ADDRESS); // RULE5
  assign do_all_lock = frame_end && whole && write_latch && (op_ff == OP_ALL_LOCK)
                       && (bidx_ff == LEN_OPCODE_ONLY); // RULE10
  assign do_all_unlock = frame_end && whole && write_latch && (op_ff == OP_ALL_UNLOCK)
                         && (bidx_ff == LEN_OPCODE_ONLY); // RULE11
  assign do_arm = frame_end && whole && (op_ff == OP_RESET_ARM) && (bidx_ff == LEN_OPCODE_ONLY);
  assign do_reset = frame_end && whole && arm_ff && (op_ff == OP_RESET_EXECUTE)
                    && (bidx_ff == LEN_OPCODE_ONLY); // RULE14
  assign nxt_addr = (bidx_ff != 5'h0) && (bidx_ff <= LOCK_LAST_ADDR_BYTE) ?
                    {addr_ff[15:0], link_byte_ff} : addr_ff;
  assign lock_byte = {7'h00, lock_ff[nxt_addr[TOP_ADDRESS_BIT:SECTOR_LSB]]}; // RULE8 RULE9
  assign pre_idx = {1'b0, bidx_ff} + 6'h02;

  // Byte prepared for the output slot two bytes ahead of the one just received.
  always_comb begin
    pre_byte = 8'h00;
    if (op_ff == OP_LOCK_STATUS_READ) begin
      pre_byte = lock_byte; // RULE8
    end else if ((op_ff == OP_UNIQUE_ID_READ) && (pre_idx >= LONG_OUT_START)
                 && (pre_idx < LONG_OUT_START + UID_BYTES)) begin
      pre_byte = UNIQUE_ID[8 * (4'hF - 4'(pre_idx - LONG_OUT_START)) +: 8]; // RULE16
    end else if ((op_ff == OP_PARAM_TABLE_READ) && (pre_idx >= LONG_OUT_START)) begin
      pre_byte = PARAM_TABLE_FILL; // RULE17
    end
  end

  // Mode only follows the pin while deselected, so the link sees a steady value.
  always_ff @(posedge clock) begin
    if (rst) begin
      mode_ff <= 1'b0;
    end else if (acc_ff[0]) begin
      mode_ff <= quad_command_mode;
    end
  end

  always_ff @(posedge clock) begin
    if (rst || frame_start) begin
      ecnt_ff <= 3'h0;
      bidx_ff <= 5'h00;
    end else if (byte_done) begin
      ecnt_ff <= 3'h0;
      bidx_ff <= (bidx_ff == IDX_WRAP_FROM) ? IDX_WRAP_TO : bidx_ff + 5'h01;
    end else if (chg[1]) begin
      ecnt_ff <= ecnt_ff + 3'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      op_ff <= OP_NO_ACTION;
      addr_ff <= 24'h000000;
    end else if (byte_done) begin
      if (bidx_ff == 5'h00) begin
        op_ff <= link_byte_ff;
      end
      addr_ff <= nxt_addr;
    end
  end

  // Output buffers and the request that tells the link when to drive.
  always_ff @(posedge clock) begin
    if (rst || frame_start || frame_end) begin
      buf0_ff <= 8'h00;
      buf1_ff <= 8'h00;
      out_arm_ff <= 1'b0;
      out_long_ff <= 1'b0;
    end else if (byte_done) begin
      if (bidx_ff == 5'h00) begin
        out_arm_ff <= (link_byte_ff == OP_LOCK_STATUS_READ) || (link_byte_ff == OP_UNIQUE_ID_READ)
                      || (link_byte_ff == OP_PARAM_TABLE_READ); // RULE16 RULE17
        out_long_ff <= (link_byte_ff != OP_LOCK_STATUS_READ);
      end
      if ((op_ff == OP_LOCK_STATUS_READ) && (bidx_ff == LOCK_LAST_ADDR_BYTE)) begin
        buf0_ff <= lock_byte; // RULE8
        buf1_ff <= lock_byte;
      end else if (bidx_ff[0]) begin
        buf1_ff <= pre_byte;
      end else begin
        buf0_ff <= pre_byte;
      end
    end
  end

  // Any completed frame other than the arm command drops the armed state.
  always_ff @(posedge clock) begin
    if (rst || do_reset) begin
      arm_ff <= 1'b0;
    end else if (frame_end) begin
      arm_ff <= do_arm; // RULE1 RULE14
    end
  end

  for (genvar i = 0; i < N_SECTORS; i++) begin : g_lock
    logic hit;
    assign hit = ((3'(i / 16) == BOTTOM_BLOCK) || (3'(i / 16) == TOP_BLOCK)) ?
                 (addr_ff[TOP_ADDRESS_BIT:SECTOR_LSB] == 7'(i)) :
                 (addr_ff[TOP_ADDRESS_BIT:BLOCK_LSB] == 3'(i / 16)); // RULE4
    always_ff @(posedge clock) begin
      if (rst || do_reset || do_all_lock) begin
        lock_ff[i] <= LOCK_RESET[i]; // RULE3 RULE13 RULE10
      end else if (do_all_unlock) begin
        lock_ff[i] <= 1'b0; // RULE11
      end else if (do_single_lock && hit) begin
        lock_ff[i] <= 1'b1; // RULE4
      end else if (do_single_unlock && hit) begin
        lock_ff[i] <= 1'b0; // RULE5
      end
    end
  end

  assign prot = lock_scheme_select ? lock_ff[pe_addr[TOP_ADDRESS_BIT:SECTOR_LSB]] :
                range_protect; // RULE2 RULE9

  always_ff @(posedge clock) begin
    if (rst) begin
      pe_grant_ff <= 1'b0;
      pe_deny_ff <= 1'b0;
    end else begin
      pe_grant_ff <= pe_req && !prot;
      pe_deny_ff <= pe_req && prot; // RULE18
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      soft_reset_ff <= 1'b0;
      pe_abort_ff <= 1'b0;
    end else begin
      soft_reset_ff <= do_reset; // RULE13
      pe_abort_ff <= do_reset && pe_busy; // RULE15
    end
  end

  assign pe_grant = pe_grant_ff;
  assign pe_deny = pe_deny_ff;
  assign pe_abort = pe_abort_ff;
  assign soft_reset = soft_reset_ff;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  AST_LOCK_AFTER_RESET: assert property ($fell(rst) |-> &lock_ff) // RULE3
    else $error("lock bits not all set after reset");
  AST_RESET_NEEDS_ARM: assert property (soft_reset_ff |-> $past(arm_ff)) // RULE14
    else $error("software reset without preceding arm");
  AST_RESET_RESTORES_LOCKS: assert property (soft_reset_ff |-> &lock_ff && !arm_ff) // RULE13
    else $error("software reset left volatile state");
  AST_NOP_ONLY_CANCELS: assert property (frame_end && op_ff == OP_NO_ACTION |=>
    $stable(lock_ff) && !arm_ff) // RULE1
    else $error("no-action command changed state");
  AST_PARTIAL_REJECTED: assert property (frame_end && !whole |=> $stable(lock_ff)) // RULE7
    else $error("partial frame changed lock bits");
  AST_ALL_LOCK: assert property (do_all_lock |=> &lock_ff) // RULE10
    else $error("all-lock did not set every bit");
  AST_ALL_UNLOCK: assert property (do_all_unlock |=> lock_ff == '0) // RULE11
    else $error("all-unlock did not clear every bit");
  AST_SINGLE_LOCK: assert property (do_single_lock |=>
    lock_ff[$past(addr_ff[TOP_ADDRESS_BIT:SECTOR_LSB])]) // RULE4
    else $error("single lock missed the addressed sector");
  AST_SINGLE_UNLOCK: assert property (do_single_unlock |=>
    !lock_ff[$past(addr_ff[TOP_ADDRESS_BIT:SECTOR_LSB])]) // RULE5
    else $error("single unlock missed the addressed sector");
  AST_LOCKED_PE_DENIED: assert property (pe_req && lock_scheme_select &&
    lock_ff[pe_addr[TOP_ADDRESS_BIT:SECTOR_LSB]] |=> pe_deny_ff && !pe_grant_ff) // RULE18
    else $error("locked block accepted program or erase");
  AST_RANGE_SCHEME: assert property (pe_req && !lock_scheme_select |=>
    pe_deny_ff == $past(range_protect)) // RULE2
    else $error("range protection not followed");
  AST_ABORT_ON_RESET: assert property (do_reset && pe_busy |=> pe_abort_ff && soft_reset_ff) // RULE15
    else $error("busy operation not aborted");

  COV_SINGLE_LOCK: cover property (do_single_lock);
  COV_STATUS_READ: cover property (out_arm_ff && !out_long_ff ##1 frame_end);
  COV_SOFT_RESET: cover property (do_arm ##[1:400] do_reset);
  COV_QUAD_BYTE: cover property (mode_ff && byte_done);
endmodule

// file: flk_pkg.sv
// Constants shared by the flash lock, reset and identity command block.
// Assumes a 4 Mbit array: 8 blocks of 64 KB, 128 sectors of 4 KB.
package flk_pkg;
  // ****************************************
  // Command codes
  // ****************************************
  localparam logic [7:0] OP_NO_ACTION = 8'h00;
  localparam logic [7:0] OP_SINGLE_LOCK = 8'h36;
  localparam logic [7:0] OP_SINGLE_UNLOCK = 8'h39;
  localparam logic [7:0] OP_LOCK_STATUS_READ = 8'h3D;
  localparam logic [7:0] OP_ALL_LOCK = 8'h7E;
  localparam logic [7:0] OP_ALL_UNLOCK = 8'h98;
  localparam logic [7:0] OP_RESET_ARM = 8'h66;
  localparam logic [7:0] OP_RESET_EXECUTE = 8'h99;
  localparam logic [7:0] OP_UNIQUE_ID_READ = 8'h4B;
  localparam logic [7:0] OP_PARAM_TABLE_READ = 8'h5A;
  // ****************************************
  // Array geometry
  // ****************************************
  localparam int TOP_ADDRESS_BIT = 18;
  localparam int SECTOR_LSB = 12;
  localparam int BLOCK_LSB = 16;
  localparam int N_SECTORS = 128;
  localparam logic [2:0] BOTTOM_BLOCK = 3'h0;
  localparam logic [2:0] TOP_BLOCK = 3'h7;
  localparam logic [N_SECTORS-1:0] LOCK_RESET = {N_SECTORS{1'b1}};
  // ****************************************
  // Frame layout counts
  // ****************************************
  localparam logic [2:0] SPI_LAST_EDGE = 3'h7;
  localparam logic [2:0] QUAD_LAST_EDGE = 3'h1;
  localparam logic [4:0] LEN_OPCODE_ONLY = 5'h01;
  localparam logic [4:0] LEN_WITH_ADDRESS = 5'h04;
  localparam logic [4:0] IDX_WRAP_FROM = 5'h1F;
  localparam logic [4:0] IDX_WRAP_TO = 5'h18;
  localparam logic [4:0] LOCK_LAST_ADDR_BYTE = 5'h03;
  localparam logic [5:0] LONG_OUT_START = 6'h05;
  localparam logic [5:0] UID_BYTES = 6'h10;
  localparam logic [6:0] SPI_OUT_EDGE = 7'h20;
  localparam logic [6:0] SPI_OUT_EDGE_LONG = 7'h28;
  localparam logic [6:0] QUAD_OUT_EDGE = 7'h08;
  localparam logic [6:0] QUAD_OUT_EDGE_LONG = 7'h0A;
  localparam logic [6:0] EDGE_SAT = 7'h7F;
  localparam logic [7:0] PARAM_TABLE_FILL = 8'hFF;
  localparam logic [1:0] SYNC_RESET = 2'h1;
endpackage

// file: flk_host.sv
// Host model: drives chip select, serial clock and I/O lanes of the flash.
// Assumes the bench fills tx before calling run and reads rx afterwards.
`timescale 1ns/10ps
module flk_host (
  output logic sclk,
  output logic cs_n,
  output logic [3:0] io_in,
  input wire logic [3:0] io_out,
  input wire logic [3:0] io_oe,
  input wire logic quad
);
  logic [7:0] tx [0:7];
  logic [7:0] rx [0:15];
  logic [3:0] oe_seen;
  // Chip select rises after time zero so the frame logic sees a clean edge.
  initial begin
    sclk = 1'b0;
    cs_n = 1'b0;
    io_in = 4'hA;
    oe_seen = 4'h0;
    for (int i = 0; i < 8; i++) tx[i] = 8'h00;
    #1;
    cs_n = 1'b1;
  end
  // ****************************************
  // Frame
  // ****************************************
  // Sends nin bytes and extra loose edges, then reads nout bytes.
  task automatic run(input int nin, input int extra, input int nout);
    int per;
    int nw;
    int k;
    per = quad ? 2 : 8;
    nw = nin * per + extra;
    cs_n = 1'b0;
    #40;
    for (int e = 0; e < nw + nout * per; e++) begin
      k = e / per;
      if (e < nw) begin
        if (quad) io_in = e[0] ? tx[k][3:0] : tx[k][7:4];
        else io_in = {e[2:0] ^ 3'h5, tx[k][7 - e % 8]};
      end else begin
        io_in = ~io_in;
      end
      #40;
      sclk = 1'b1;
      if (e >= nw) begin
        k = (e - nw) / per;
        rx[k] = quad ? {rx[k][3:0], io_out} : {rx[k][6:0], io_out[1]};
        oe_seen = io_oe;
      end
      #40;
      sclk = 1'b0;
    end
    cs_n = 1'b1;
    io_in = ~io_in;
    #200;
  endtask
endmodule

// file: test_flk_cmd.sv
// Testbench: lock, reset, identity and table commands through the host model.
// Assumes flk_pkg, flk_cmd and flk_host are compiled first.
`timescale 1ns/10ps
module test_flk_cmd;
  import flk_pkg::*;
  // Arbitrary identity value.
  localparam logic [127:0] UID = 128'h00112233445566778899AABBCCDDEEFF;
  logic clock, rst, quad_command_mode, lock_scheme_select, range_protect;
  logic write_latch, pe_req, pe_busy, pe_grant, pe_deny, pe_abort, soft_reset;
  logic sclk, cs_n;
  logic [3:0] io_in, io_out, io_oe;
  logic [23:0] pe_addr;
  logic [127:0] got;
  int n_mismatch, check_count, n_soft, n_abort;
  flk_cmd #(.UNIQUE_ID(UID)) u_dut (.clock(clock), .rst(rst), .sclk(sclk), .cs_n(cs_n),
    .io_in(io_in), .io_out(io_out), .io_oe(io_oe), .quad_command_mode(quad_command_mode),
    .lock_scheme_select(lock_scheme_select), .range_protect(range_protect),
    .write_latch(write_latch), .pe_req(pe_req), .pe_addr(pe_addr), .pe_busy(pe_busy),
    .pe_grant(pe_grant), .pe_deny(pe_deny), .pe_abort(pe_abort), .soft_reset(soft_reset));
  flk_host u_host (.sclk(sclk), .cs_n(cs_n), .io_in(io_in), .io_out(io_out),
    .io_oe(io_oe), .quad(quad_command_mode));
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  always @(posedge clock) begin
    if (soft_reset === 1'b1) n_soft++;
    if (pe_abort === 1'b1) n_abort++;
  end
  // ****************************************
  // Helpers
  // ****************************************
  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic load(input logic [7:0] op, input logic [23:0] a);
    u_host.tx[0] = op;
    {u_host.tx[1], u_host.tx[2], u_host.tx[3]} = a;
  endtask
  task automatic cmd(input logic [7:0] op, input logic [23:0] a, input int n, input int x);
    load(op, a);
    u_host.run(n, x, 0);
  endtask
  task automatic status(input logic [23:0] a, input logic exp);
    load(OP_LOCK_STATUS_READ, a);
    u_host.run(4, 0, 2);
    check(u_host.rx[0], {7'h00, exp});
    check(u_host.rx[1], {7'h00, exp});
    check(u_host.oe_seen, quad_command_mode ? 4'hF : 4'h2);
    check(io_oe, 4'h0);
  endtask
  task automatic pe(input logic [23:0] a, input logic g);
    @(negedge clock);
    pe_req = 1'b1;
    pe_addr = a;
    @(negedge clock);
    pe_req = 1'b0;
    check({pe_grant, pe_deny}, {g, ~g});
    @(negedge clock);
    check({pe_grant, pe_deny}, 2'h0);
  endtask
  task automatic done(input int t);
    $display("Test %0d done", t);
  endtask
  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    #500000;
    n_mismatch++;
    stop_test();
  end
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    {rst, quad_command_mode, range_protect, pe_req, pe_busy} = 5'h00;
    {lock_scheme_select, write_latch} = 2'h3;
    pe_addr = 24'h000000;
    // Reset rises after time zero so every reset edge is seen.
    #1;
    rst = 1'b1;
    repeat (20) @(negedge clock);
    rst = 1'b0;
    repeat (4) @(negedge clock);
    status(24'h000000, 1'b1);
    status(24'h07F000, 1'b1);
    status(24'h030000, 1'b1);
    done(1);
    cmd(OP_SINGLE_UNLOCK, 24'h001000, 4, 0);
    status(24'h001000, 1'b0);
    status(24'h002000, 1'b1);
    pe(24'h001ABC, 1'b1);
    pe(24'h002000, 1'b0);
    cmd(OP_SINGLE_UNLOCK, 24'h035000, 4, 0);
    status(24'h03F000, 1'b0);
    cmd(OP_SINGLE_LOCK, 24'h03A000, 4, 0);
    status(24'h030000, 1'b1);
    done(2);
    @(negedge clock);
    lock_scheme_select = 1'b0;
    pe(24'h002000, 1'b1);
    range_protect = 1'b1;
    pe(24'h001000, 1'b0);
    {lock_scheme_select, range_protect} = 2'h2;
    done(3);
    cmd(OP_SINGLE_UNLOCK, 24'h002000, 4, 1);
    cmd(OP_SINGLE_UNLOCK, 24'h002000, 3, 7);
    @(negedge clock);
    write_latch = 1'b0;
    cmd(OP_SINGLE_UNLOCK, 24'h002000, 4, 0);
    @(negedge clock);
    write_latch = 1'b1;
    status(24'h002000, 1'b1);
    done(4);
    @(negedge clock);
    quad_command_mode = 1'b1;
    cmd(OP_ALL_UNLOCK, 24'h000000, 1, 0);
    status(24'h004000, 1'b0);
    status(24'h07F000, 1'b0);
    cmd(OP_ALL_LOCK, 24'h000000, 1, 0);
    cmd(OP_ALL_UNLOCK, 24'h000000, 1, 1);
    status(24'h010000, 1'b1);
    @(negedge clock);
    quad_command_mode = 1'b0;
    done(5);
    cmd(OP_ALL_UNLOCK, 24'h000000, 1, 0);
    cmd(OP_RESET_ARM, 24'h000000, 1, 0);
    cmd(OP_NO_ACTION, 24'h000000, 1, 0);
    cmd(OP_RESET_EXECUTE, 24'h000000, 1, 0);
    check(n_soft, 0);
    status(24'h001000, 1'b0);
    cmd(OP_RESET_ARM, 24'h000000, 1, 0);
    @(negedge clock);
    pe_busy = 1'b1;
    cmd(OP_RESET_EXECUTE, 24'h000000, 1, 0);
    @(negedge clock);
    pe_busy = 1'b0;
    check(n_soft, 1);
    check(n_abort, 1);
    status(24'h001000, 1'b1);
    done(6);
    u_host.tx[4] = 8'h00;
    load(OP_UNIQUE_ID_READ, 24'h000000);
    u_host.run(5, 0, 16);
    for (int i = 0; i < 16; i++) got = {got[119:0], u_host.rx[i]};
    check(got, UID);
    done(7);
    load(OP_PARAM_TABLE_READ, 24'h000010);
    u_host.run(5, 0, 2);
    check({u_host.rx[0], u_host.rx[1]}, {PARAM_TABLE_FILL, PARAM_TABLE_FILL});
    status(24'h000000, 1'b1);
    done(8);
    stop_test();
  end
endmodule
